// ### rtl/fwps_core.sv
// Write protection, busy flag and status lock of the serial flash
`timescale 1ns/100ps
`include "fwps_regs.svh"

module fwps_core #(
  parameter int TPU_NS = `FWPS_TPU_NS,
  parameter int OP_NS  = `FWPS_OP_NS
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        power_good_i,
  input  wire logic        write_protect_n_i,
  input  wire logic        link_clk_i,
  input  wire logic        link_rst_i,
  input  wire logic        cmd_valid_i,
  input  wire logic [3:0]  cmd_code_i,
  input  wire logic [23:0] cmd_addr_i,
  input  wire logic [15:0] cmd_data_i,
  input  wire logic        cmd_quad_i,
  output logic      [7:0]  status_byte_one_o,
  output logic      [7:0]  status_byte_two_o,
  output logic             op_start_o,
  output logic             cmd_refused_o
);

  // Lockout rounds up, operation time rounds down, both at least one cycle
  localparam int LOCKOUT_RAW = (TPU_NS * `FWPS_CLK_KHZ + 999999) / 1000000;
  localparam int LOCKOUT_CYC = (LOCKOUT_RAW < 1) ? 1 : LOCKOUT_RAW;
  localparam int OP_RAW      = (OP_NS * `FWPS_CLK_KHZ) / 1000000;
  localparam int OP_CYC      = (OP_RAW < 1) ? 1 : OP_RAW;

  // Link side: capture the decoded command and flag it with a toggle
  logic        link_tog;
  logic [3:0]  hold_code;
  logic [23:0] hold_addr;
  logic [15:0] hold_data;
  logic        hold_quad;
  logic        next_link_tog;
  logic [3:0]  next_hold_code;
  logic [23:0] next_hold_addr;
  logic [15:0] next_hold_data;
  logic        next_hold_quad;

  always_comb
  begin
    next_link_tog  = link_tog ^ cmd_valid_i;
    next_hold_code = cmd_valid_i ? cmd_code_i : hold_code;
    next_hold_addr = cmd_valid_i ? cmd_addr_i : hold_addr;
    next_hold_data = cmd_valid_i ? cmd_data_i : hold_data;
    next_hold_quad = cmd_valid_i ? cmd_quad_i : hold_quad;
  end

  always_ff @(posedge link_clk_i)
  begin
    if (link_rst_i)
    begin
      link_tog  <= 1'b0;
      hold_code <= 4'h0;
      hold_addr <= 24'h000000;
      hold_data <= 16'h0000;
      hold_quad <= 1'b0;
    end
    else
    begin
      link_tog  <= next_link_tog;
      hold_code <= next_hold_code;
      hold_addr <= next_hold_addr;
      hold_data <= next_hold_data;
      hold_quad <= next_hold_quad;
    end
  end

  // System side synchronisers; holding words are stable once the toggle lands
  logic tog_s1, tog_s2, tog_s3;
  logic pg_s1, pg_s2;
  logic wp_s1, wp_s2;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      tog_s1 <= 1'b0;
      tog_s2 <= 1'b0;
      tog_s3 <= 1'b0;
      pg_s1  <= 1'b0;
      pg_s2  <= 1'b0;
      wp_s1  <= 1'b0;
      wp_s2  <= 1'b0;
    end
    else
    begin
      tog_s1 <= link_tog;
      tog_s2 <= tog_s1;
      tog_s3 <= tog_s2;
      pg_s1  <= power_good_i;
      pg_s2  <= pg_s1;
      wp_s1  <= write_protect_n_i;
      wp_s2  <= wp_s1;
    end
  end

  logic new_cmd;
  logic pwr_ok;
  assign new_cmd = tog_s2 ^ tog_s3;
  assign pwr_ok  = pg_s2;

  // Protection state and its next values
  fwps_pkg::fwps_state_t state, next_state;
  logic        write_enable_latch, next_wel;
  logic [2:0]  bp, next_bp;
  logic        tb, next_tb;
  logic        sec, next_sec;
  logic [1:0]  lockm, next_lockm;
  logic        qe, next_qe;
  logic        cmp, next_cmp;
  logic [15:0] op_cnt, next_op_cnt;
  logic [15:0] lock_cnt, next_lock_cnt;
  logic        next_op_start;
  logic        next_refused;
  logic [15:0] next_stat;

  // Region hit for one address, inverted by the complement bit
  function automatic logic prot_hit(input logic [23:0] a,
                                    input logic [2:0]  b,
                                    input logic        t,
                                    input logic        s,
                                    input logic        c);
    logic [24:0] size;
    logic        hit;
    size = 25'h0000000;
    if (b == 3'h0)
      size = 25'h0000000;
    else if (!s)
      size = (b == 3'h7) ? `FWPS_ARRAY_SIZE
                         : 25'h0000001 << (5'(b) + 5'h11);
    else
      size = 25'h0000001 << ((b > 3'h3) ? 5'h0F : 5'(b) + 5'h0B);
    if (t)
      hit = {1'b0, a} < size;
    else
      hit = {1'b0, a} >= (`FWPS_ARRAY_SIZE - size);
    prot_hit = hit ^ c;
  endfunction : prot_hit

  fwps_pkg::fwps_cmd_t cmd;
  logic [23:0] lo_addr, hi_addr;
  logic        range_prot;
  logic        wp_high;
  logic        sr_writable;
  logic        lockout;
  logic        is_array_op;

  always_comb
  begin
    cmd = fwps_pkg::fwps_cmd_t'(hold_code);
    lo_addr = hold_addr;
    hi_addr = hold_addr;
    unique case (cmd)
      fwps_pkg::CMD_SECT_ERASE:
      begin
        lo_addr = hold_addr & ~`FWPS_SECT_MASK;
        hi_addr = hold_addr | `FWPS_SECT_MASK;
      end
      fwps_pkg::CMD_BLK_ERASE:
      begin
        lo_addr = hold_addr & ~`FWPS_BLK_MASK;
        hi_addr = hold_addr | `FWPS_BLK_MASK;
      end
      fwps_pkg::CMD_CHIP_ERASE:
      begin
        lo_addr = 24'h000000;
        hi_addr = 24'hFFFFFF;
      end
      default:
      begin
        lo_addr = hold_addr;
        hi_addr = hold_addr;
      end
    endcase
    range_prot = prot_hit(lo_addr, bp, tb, sec, cmp)
               | prot_hit(hi_addr, bp, tb, sec, cmp);
    // Pin only counts outside quad use; floating it high costs nothing
    wp_high = wp_s2 | qe | hold_quad;
    unique case (lockm)
      `FWPS_LOCK_SW:  sr_writable = 1'b1;
      `FWPS_LOCK_HW:  sr_writable = wp_high;
      `FWPS_LOCK_PWR: sr_writable = 1'b0;
      `FWPS_LOCK_OTP: sr_writable = 1'b0;
    endcase
    lockout = lock_cnt != 16'h0000;
    is_array_op = (cmd == fwps_pkg::CMD_PROG)
                | (cmd == fwps_pkg::CMD_SECT_ERASE)
                | (cmd == fwps_pkg::CMD_BLK_ERASE)
                | (cmd == fwps_pkg::CMD_CHIP_ERASE)
                | (cmd == fwps_pkg::CMD_SECREG_WRITE);
  end

  always_comb
  begin
    next_state    = state;
    next_wel      = write_enable_latch;
    next_bp       = bp;
    next_tb       = tb;
    next_sec      = sec;
    next_lockm    = lockm;
    next_qe       = qe;
    next_cmp      = cmp;
    next_op_cnt   = op_cnt;
    next_lock_cnt = lockout ? lock_cnt - 16'h0001 : lock_cnt;
    next_op_start = 1'b0;
    next_refused  = 1'b0;
    if (!pwr_ok)
    begin
      next_state    = fwps_pkg::ST_OFF;
      next_wel      = 1'b0;
      next_op_cnt   = 16'h0000;
      next_lock_cnt = 16'(LOCKOUT_CYC);
      if (lockm == `FWPS_LOCK_PWR)
        next_lockm = `FWPS_LOCK_SW;
    end
    else
    begin
      unique case (state)
        fwps_pkg::ST_OFF:
          next_state = fwps_pkg::ST_RUN;
        fwps_pkg::ST_RUN:
        begin
          if (new_cmd)
          begin
            if (cmd == fwps_pkg::CMD_WREN)
            begin
              if (lockout)
                next_refused = 1'b1;
              else
                next_wel = 1'b1;
            end
            else if (cmd == fwps_pkg::CMD_WRDI)
              next_wel = 1'b0;
            else if (is_array_op)
            begin
              if (lockout || !write_enable_latch ||
                  (range_prot && cmd != fwps_pkg::CMD_SECREG_WRITE))
                next_refused = 1'b1;
              else
              begin
                next_wel      = 1'b0;
                next_state    = fwps_pkg::ST_BUSY;
                next_op_cnt   = 16'(OP_CYC);
                next_op_start = 1'b1;
              end
            end
            else if (cmd == fwps_pkg::CMD_STAT_WRITE)
            begin
              if (lockout || !write_enable_latch || !sr_writable)
                next_refused = 1'b1;
              else
              begin
                next_wel   = 1'b0;
                next_bp    = hold_data[`FWPS_SR_BP_HI:`FWPS_SR_BP_LO];
                next_tb    = hold_data[`FWPS_SR_TB];
                next_sec   = hold_data[`FWPS_SR_SEC];
                next_lockm = {hold_data[`FWPS_SR_LOCK_HI],
                              hold_data[`FWPS_SR_LOCK_LO]};
                next_qe    = hold_data[`FWPS_SR_QE];
                next_cmp   = hold_data[`FWPS_SR_CMP];
                next_state = fwps_pkg::ST_BUSY;
                next_op_cnt   = 16'(OP_CYC);
                next_op_start = 1'b1;
              end
            end
            else if (cmd == fwps_pkg::CMD_PDOWN)
              next_state = fwps_pkg::ST_PDOWN;
          end
        end
        fwps_pkg::ST_BUSY:
        begin
          next_op_cnt = op_cnt - 16'h0001;
          if (op_cnt == 16'h0001)
          begin
            next_state = fwps_pkg::ST_RUN;
            next_wel   = 1'b0;
          end
          if (new_cmd && cmd != fwps_pkg::CMD_STAT_READ &&
              cmd != fwps_pkg::CMD_SUSPEND)
            next_refused = 1'b1;
        end
        fwps_pkg::ST_PDOWN:
        begin
          if (new_cmd)
          begin
            if (cmd == fwps_pkg::CMD_PDOWN_EXIT)
              next_state = fwps_pkg::ST_RUN;
            else
              next_refused = 1'b1;
          end
        end
      endcase
    end
    next_stat = 16'h0000;
    next_stat[`FWPS_SR_BUSY] = next_state == fwps_pkg::ST_BUSY;
    next_stat[`FWPS_SR_WEL]  = next_wel;
    next_stat[`FWPS_SR_BP_HI:`FWPS_SR_BP_LO] = next_bp;
    next_stat[`FWPS_SR_TB]      = next_tb;
    next_stat[`FWPS_SR_SEC]     = next_sec;
    next_stat[`FWPS_SR_LOCK_LO] = next_lockm[0];
    next_stat[`FWPS_SR_LOCK_HI] = next_lockm[1];
    next_stat[`FWPS_SR_QE]      = next_qe;
    next_stat[`FWPS_SR_CMP]     = next_cmp;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state             <= fwps_pkg::ST_OFF;
      write_enable_latch               <= 1'b0;
      bp                <= `FWPS_BP_RST;
      tb                <= 1'b0;
      sec               <= 1'b0;
      lockm             <= `FWPS_LOCK_RST;
      qe                <= 1'b0;
      cmp               <= 1'b0;
      op_cnt            <= 16'h0000;
      lock_cnt          <= 16'(LOCKOUT_CYC);
      op_start_o        <= 1'b0;
      cmd_refused_o     <= 1'b0;
      status_byte_one_o <= 8'h00;
      status_byte_two_o <= 8'h00;
    end
    else
    begin
      state             <= next_state;
      write_enable_latch               <= next_wel;
      bp                <= next_bp;
      tb                <= next_tb;
      sec               <= next_sec;
      lockm             <= next_lockm;
      qe                <= next_qe;
      cmp               <= next_cmp;
      op_cnt            <= next_op_cnt;
      lock_cnt          <= next_lock_cnt;
      op_start_o        <= next_op_start;
      cmd_refused_o     <= next_refused;
      status_byte_one_o <= next_stat[7:0];
      status_byte_two_o <= next_stat[15:8];
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_run_cmd(fwps_pkg::fwps_cmd_t c);
    pwr_ok && state == fwps_pkg::ST_RUN && new_cmd && cmd == c;
  endsequence

  sequence s_busy_done;
    ##[1:OP_CYC] !status_byte_one_o[`FWPS_SR_BUSY];
  endsequence

  a_power_off_reset: assert property (
    !pwr_ok |=> state == fwps_pkg::ST_OFF && !write_enable_latch)
    else $error("state kept while power is low");

  a_lockout_wren: assert property (
    s_run_cmd(fwps_pkg::CMD_WREN) and lockout |=> cmd_refused_o && !write_enable_latch)
    else $error("write enable taken during lockout");

  a_wel_set: assert property (
    s_run_cmd(fwps_pkg::CMD_WREN) and !lockout
      |=> status_byte_one_o[`FWPS_SR_WEL])
    else $error("latch not set by write enable");

  a_no_wel_refuse: assert property (
    s_run_cmd(fwps_pkg::CMD_PROG) and !write_enable_latch |=> cmd_refused_o && !op_start_o)
    else $error("program accepted without latch");

  a_busy_bound: assert property (
    op_start_o |-> status_byte_one_o[`FWPS_SR_BUSY] ##0 s_busy_done)
    else $error("busy flag never cleared");

  a_wel_done_clear: assert property (
    $fell(status_byte_one_o[`FWPS_SR_BUSY]) && pwr_ok
      |-> !status_byte_one_o[`FWPS_SR_WEL])
    else $error("latch set after operation end");

  a_busy_ignore: assert property (
    pwr_ok && state == fwps_pkg::ST_BUSY && new_cmd &&
    cmd != fwps_pkg::CMD_STAT_READ && cmd != fwps_pkg::CMD_SUSPEND
      |=> cmd_refused_o)
    else $error("command obeyed while busy");

  a_pdown_ignore: assert property (
    pwr_ok && state == fwps_pkg::ST_PDOWN && new_cmd &&
    cmd != fwps_pkg::CMD_PDOWN_EXIT
      |=> cmd_refused_o && state == fwps_pkg::ST_PDOWN)
    else $error("command obeyed in power-down");

  a_hw_lock: assert property (
    s_run_cmd(fwps_pkg::CMD_STAT_WRITE) and lockm == `FWPS_LOCK_HW &&
    !wp_s2 && !qe && !hold_quad
      |=> cmd_refused_o && !status_byte_one_o[`FWPS_SR_BUSY] && $stable(bp))
    else $error("status write passed a low protect pin");

  a_otp_lock: assert property (
    lockm == `FWPS_LOCK_OTP && pwr_ok |=> lockm == `FWPS_LOCK_OTP)
    else $error("permanent lock mode changed");

  a_pwr_unlock: assert property (
    lockm == `FWPS_LOCK_PWR && !pwr_ok |=> lockm == `FWPS_LOCK_SW)
    else $error("lock-down survived power cycle");

  a_prot_drop: assert property (
    s_run_cmd(fwps_pkg::CMD_SECT_ERASE) and write_enable_latch && !lockout && range_prot
      |=> cmd_refused_o && !op_start_o && write_enable_latch)
    else $error("protected erase not dropped");

endmodule : fwps_core

// ### rtl/fwps_pkg.sv
// Types shared by the flash write-protect block
package fwps_pkg;

  typedef enum logic [3:0] {
    CMD_NONE,
    CMD_WREN,
    CMD_WRDI,
    CMD_PROG,
    CMD_SECT_ERASE,
    CMD_BLK_ERASE,
    CMD_CHIP_ERASE,
    CMD_STAT_WRITE,
    CMD_STAT_READ,
    CMD_SUSPEND,
    CMD_PDOWN,
    CMD_PDOWN_EXIT,
    CMD_SECREG_WRITE,
    CMD_OTHER
  } fwps_cmd_t;

  typedef enum logic [1:0] {
    ST_OFF,
    ST_RUN,
    ST_BUSY,
    ST_PDOWN
  } fwps_state_t;

endpackage : fwps_pkg

// ### rtl/fwps_regs.svh
// Offsets, field positions, reset values and timing of the protect block
// Function
// - Below the write-inhibit voltage the block stays reset and takes no command.
// - After power-up, write-class commands are refused until the lockout delay ends.
// - The write enable latch starts at zero after power-up.
// - Program, erase and status write need a prior write enable; else rejected.
// - Finishing a program, erase or status write clears the latch.
// - In power-down only the release command is obeyed.
// - Status bit 0 reads one while any write operation runs.
// - While busy only status reads and suspend are accepted.
// - Completion of the internal operation clears the busy flag.
// - Status bit 1, the latch, becomes one after write enable.
// - Write disable or an accepted write-class command clears the latch.
// - Bits 4 to 2 size the protected region; default zero protects nothing.
// - Top/bottom select puts the region at top when 0, bottom when 1.
// - Unit select counts 4KB sectors when 1, 64KB blocks when 0.
// - Bit 14 inverts the chosen protection; default zero.
// - Lock mode bits sit at status bits 8 and 7.
// - Lock mode 01 with protect pin low refuses every status write in single and dual operation.
// - Lock mode 01 with protect pin high allows status write with the latch.
// - Lock mode 10 refuses status writes until a power cycle, which restores 00.
// - Lock mode 11 refuses status writes permanently.
// - The protect pin gates status writes only in single and dual operation.
// - With quad enable set the protect pin function is disabled.
`ifndef FWPS_REGS_SVH
`define FWPS_REGS_SVH

`define FWPS_SR_BUSY      0
`define FWPS_SR_WEL       1
`define FWPS_SR_BP_LO     2
`define FWPS_SR_BP_HI     4
`define FWPS_SR_TB        5
`define FWPS_SR_SEC       6
`define FWPS_SR_LOCK_LO   7
`define FWPS_SR_LOCK_HI   8
`define FWPS_SR_QE        9
`define FWPS_SR_CMP       14

`define FWPS_BP_RST       3'h0
`define FWPS_LOCK_RST     2'h0
`define FWPS_LOCK_SW      2'h0
`define FWPS_LOCK_HW      2'h1
`define FWPS_LOCK_PWR     2'h2
`define FWPS_LOCK_OTP     2'h3

`define FWPS_ARRAY_SIZE   25'h1000000
`define FWPS_SECT_MASK    24'h000FFF
`define FWPS_BLK_MASK     24'h00FFFF

`define FWPS_CLK_KHZ      25000
`define FWPS_TPU_NS       100000
`define FWPS_OP_NS        20000

`endif

// ### sim/flash_write_protect_status_tb_top.sv
// Self-checking bench for the flash write-protect and status block
`timescale 1ns/100ps

module flash_write_protect_status_tb_top;
  // Short lockout and operation times keep the run brief
  localparam int POWERUP_WRITE_LOCKOUT_DELAY = 800;
  localparam int OP  = 2000;

  logic        clk_i;
  logic        link_clk_i;
  logic        rst_i;
  logic        link_rst_i;
  logic        power_good_i;
  logic        write_protect_n_i;
  logic        go;
  logic [3:0]  code;
  logic [23:0] addr;
  logic [15:0] data;
  logic        quad;
  logic        cmd_valid_i;
  logic [3:0]  cmd_code_i;
  logic [23:0] cmd_addr_i;
  logic [15:0] cmd_data_i;
  logic        cmd_quad_i;
  logic [7:0]  status_byte_one_o;
  logic [7:0]  status_byte_two_o;
  logic        op_start_o;
  logic        cmd_refused_o;
  logic        started;
  logic        refused;
  int          n_errors;
  int          checked;

  initial clk_i = 1'h0;
  always #20 clk_i = ~clk_i;

  // Link clock phase is offset so its edges never meet the system clock
  initial
  begin
    link_clk_i = 1'h0;
    #3.3;
    forever #7.5 link_clk_i = ~link_clk_i;
  end

  fwps_core #(
    .TPU_NS (POWERUP_WRITE_LOCKOUT_DELAY),
    .OP_NS  (OP)
  ) u_fwps_core (
    .clk_i             (clk_i),
    .rst_i             (rst_i),
    .power_good_i      (power_good_i),
    .write_protect_n_i (write_protect_n_i),
    .link_clk_i        (link_clk_i),
    .link_rst_i        (link_rst_i),
    .cmd_valid_i       (cmd_valid_i),
    .cmd_code_i        (cmd_code_i),
    .cmd_addr_i        (cmd_addr_i),
    .cmd_data_i        (cmd_data_i),
    .cmd_quad_i        (cmd_quad_i),
    .status_byte_one_o (status_byte_one_o),
    .status_byte_two_o (status_byte_two_o),
    .op_start_o        (op_start_o),
    .cmd_refused_o     (cmd_refused_o)
  );

  fwps_host_model u_fwps_host_model (
    .link_clk_i  (link_clk_i),
    .go_i        (go),
    .code_i      (code),
    .addr_i      (addr),
    .data_i      (data),
    .quad_i      (quad),
    .cmd_valid_o (cmd_valid_i),
    .cmd_code_o  (cmd_code_i),
    .cmd_addr_o  (cmd_addr_i),
    .cmd_data_o  (cmd_data_i),
    .cmd_quad_o  (cmd_quad_i)
  );

  task automatic summarize;
    if (n_errors == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : summarize

  task automatic chk(input string what, input logic [15:0] exp,
                     input logic [15:0] got);
    checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic sr(input logic [15:0] exp);
    chk("status", exp, {status_byte_two_o, status_byte_one_o});
  endtask : sr

  // Waits out the crossing; the spacing also covers the minimum gap
  task automatic send(input fwps_pkg::fwps_cmd_t c, input logic [23:0] a,
                      input logic [15:0] d, input logic q);
    code    = c;
    addr    = a;
    data    = d;
    quad    = q;
    go      = ~go;
    started = 1'h0;
    refused = 1'h0;
    repeat (16)
    begin
      @(negedge clk_i);
      if (op_start_o === 1'h1)
        started = 1'h1;
      if (cmd_refused_o === 1'h1)
        refused = 1'h1;
    end
  endtask : send

  task automatic op(input fwps_pkg::fwps_cmd_t c, input logic [23:0] a,
                    input logic [15:0] d, input logic q, input logic es,
                    input logic er);
    send(c, a, d, q);
    chk("op start", {15'h0, es}, {15'h0, started});
    chk("refused", {15'h0, er}, {15'h0, refused});
    repeat (80)
      if (status_byte_one_o[0] !== 1'h0)
        @(negedge clk_i);
  endtask : op

  task automatic wop(input fwps_pkg::fwps_cmd_t c, input logic [23:0] a,
                     input logic [15:0] d, input logic q, input logic es);
    op(fwps_pkg::CMD_WREN, 24'h0, 16'h0, 1'h0, 1'h0, 1'h0);
    op(c, a, d, q, es, ~es);
  endtask : wop

  task automatic pcycle;
    @(negedge clk_i);
    power_good_i = 1'h0;
    repeat (4) @(negedge clk_i);
    power_good_i = 1'h1;
    repeat (40) @(negedge clk_i);
  endtask : pcycle

  task automatic t_power;
    send(fwps_pkg::CMD_WREN, 24'h0, 16'h0, 1'h0);
    chk("lost cmd", 16'h0, {14'h0, started, refused});
    sr(16'h0000);
    @(negedge clk_i);
    power_good_i = 1'h1;
    repeat (4) @(negedge clk_i);
    op(fwps_pkg::CMD_WREN, 24'h0, 16'h0, 1'h0, 1'h0, 1'h1);
    sr(16'h0000);
    repeat (40) @(negedge clk_i);
  endtask : t_power

  task automatic t_latch;
    op(fwps_pkg::CMD_PROG, 24'h1000, 16'h0, 1'h0, 1'h0, 1'h1);
    op(fwps_pkg::CMD_WREN, 24'h0, 16'h0, 1'h0, 1'h0, 1'h0);
    sr(16'h0002);
    op(fwps_pkg::CMD_WRDI, 24'h0, 16'h0, 1'h0, 1'h0, 1'h0);
    sr(16'h0000);
  endtask : t_latch

  task automatic t_busy;
    fwps_pkg::fwps_cmd_t wc [3];
    wc = '{fwps_pkg::CMD_SECT_ERASE, fwps_pkg::CMD_BLK_ERASE,
           fwps_pkg::CMD_SECREG_WRITE};
    op(fwps_pkg::CMD_WREN, 24'h0, 16'h0, 1'h0, 1'h0, 1'h0);
    send(fwps_pkg::CMD_PROG, 24'h100, 16'h0, 1'h0);
    chk("prog start", 16'h1, {15'h0, started});
    sr(16'h0001);
    send(fwps_pkg::CMD_WREN, 24'h0, 16'h0, 1'h0);
    chk("busy wren", 16'h1, {15'h0, refused});
    send(fwps_pkg::CMD_SUSPEND, 24'h0, 16'h0, 1'h0);
    chk("busy suspend", 16'h0, {15'h0, refused});
    send(fwps_pkg::CMD_STAT_READ, 24'h0, 16'h0, 1'h0);
    chk("busy read", 16'h0, {15'h0, refused});
    repeat (80)
      if (status_byte_one_o[0] !== 1'h0)
        @(negedge clk_i);
    sr(16'h0000);
    foreach (wc[i])
      wop(wc[i], 24'h2000, 16'h0, 1'h0, 1'h1);
    wop(fwps_pkg::CMD_CHIP_ERASE, 24'h0, 16'h0, 1'h0, 1'h1);
  endtask : t_busy

  task automatic t_prot;
    wop(fwps_pkg::CMD_STAT_WRITE, 24'h0, 16'h0004, 1'h0, 1'h1);
    wop(fwps_pkg::CMD_PROG, 24'hFC0000, 16'h0, 1'h0, 1'h0);
    sr(16'h0006);
    op(fwps_pkg::CMD_SECT_ERASE, 24'hFC1000, 16'h0, 1'h0, 1'h0, 1'h1);
    sr(16'h0006);
    wop(fwps_pkg::CMD_PROG, 24'hFBF000, 16'h0, 1'h0, 1'h1);
    wop(fwps_pkg::CMD_STAT_WRITE, 24'h0, 16'h0024, 1'h0, 1'h1);
    wop(fwps_pkg::CMD_PROG, 24'h03F000, 16'h0, 1'h0, 1'h0);
    wop(fwps_pkg::CMD_PROG, 24'h040000, 16'h0, 1'h0, 1'h1);
    wop(fwps_pkg::CMD_STAT_WRITE, 24'h0, 16'h0064, 1'h0, 1'h1);
    wop(fwps_pkg::CMD_PROG, 24'h000000, 16'h0, 1'h0, 1'h0);
    wop(fwps_pkg::CMD_PROG, 24'h001000, 16'h0, 1'h0, 1'h1);
    wop(fwps_pkg::CMD_STAT_WRITE, 24'h0, 16'h4004, 1'h0, 1'h1);
    sr(16'h4004);
    wop(fwps_pkg::CMD_PROG, 24'hFC0000, 16'h0, 1'h0, 1'h1);
    wop(fwps_pkg::CMD_PROG, 24'h000000, 16'h0, 1'h0, 1'h0);
    wop(fwps_pkg::CMD_STAT_WRITE, 24'h0, 16'h0000, 1'h0, 1'h1);
  endtask : t_prot

  task automatic t_pdown;
    op(fwps_pkg::CMD_PDOWN, 24'h0, 16'h0, 1'h0, 1'h0, 1'h0);
    op(fwps_pkg::CMD_WREN, 24'h0, 16'h0, 1'h0, 1'h0, 1'h1);
    op(fwps_pkg::CMD_PDOWN_EXIT, 24'h0, 16'h0, 1'h0, 1'h0, 1'h0);
    op(fwps_pkg::CMD_WREN, 24'h0, 16'h0, 1'h0, 1'h0, 1'h0);
    op(fwps_pkg::CMD_WRDI, 24'h0, 16'h0, 1'h0, 1'h0, 1'h0);
  endtask : t_pdown

  task automatic t_lock;
    wop(fwps_pkg::CMD_STAT_WRITE, 24'h0, 16'h0080, 1'h0, 1'h1);
    sr(16'h0080);
    @(negedge clk_i);
    write_protect_n_i = 1'h0;
    wop(fwps_pkg::CMD_STAT_WRITE, 24'h0, 16'h0084, 1'h0, 1'h0);
    sr(16'h0082);
    wop(fwps_pkg::CMD_STAT_WRITE, 24'h0, 16'h0084, 1'h1, 1'h1);
    @(negedge clk_i);
    write_protect_n_i = 1'h1;
    wop(fwps_pkg::CMD_STAT_WRITE, 24'h0, 16'h0280, 1'h0, 1'h1);
    @(negedge clk_i);
    write_protect_n_i = 1'h0;
    wop(fwps_pkg::CMD_STAT_WRITE, 24'h0, 16'h0288, 1'h0, 1'h1);
    sr(16'h0288);
    wop(fwps_pkg::CMD_STAT_WRITE, 24'h0, 16'h0100, 1'h0, 1'h1);
    wop(fwps_pkg::CMD_STAT_WRITE, 24'h0, 16'h0000, 1'h0, 1'h0);
    pcycle;
    sr(16'h0000);
    wop(fwps_pkg::CMD_STAT_WRITE, 24'h0, 16'h0180, 1'h1, 1'h1);
    pcycle;
    wop(fwps_pkg::CMD_STAT_WRITE, 24'h0, 16'h0000, 1'h1, 1'h0);
    sr(16'h0182);
  endtask : t_lock

  initial
  begin
    n_errors          = 0;
    checked           = 0;
    rst_i             = 1'h1;
    link_rst_i        = 1'h1;
    power_good_i      = 1'h0;
    write_protect_n_i = 1'h1;
    go                = 1'h0;
    code              = 4'h0;
    addr              = 24'h0;
    data              = 16'h0;
    quad              = 1'h0;
    repeat (6) @(negedge clk_i);
    rst_i = 1'h0;
    @(negedge link_clk_i);
    link_rst_i = 1'h0;
    repeat (2) @(negedge clk_i);
    t_power;
    t_latch;
    t_busy;
    t_prot;
    t_pdown;
    t_lock;
    summarize;
  end

  // About 68 operations of under 100 cycles each fit well inside this span
  initial
  begin
    #1000000;
    n_errors++;
    summarize;
  end
endmodule : flash_write_protect_status_tb_top

// ### sim/fwps_host_model.sv
// Host-side command issuer for the link clock domain
`timescale 1ns/100ps

module fwps_host_model (
  input  wire logic        link_clk_i,
  input  wire logic        go_i,
  input  wire logic [3:0]  code_i,
  input  wire logic [23:0] addr_i,
  input  wire logic [15:0] data_i,
  input  wire logic        quad_i,
  output logic             cmd_valid_o,
  output logic      [3:0]  cmd_code_o,
  output logic      [23:0] cmd_addr_o,
  output logic      [15:0] cmd_data_o,
  output logic             cmd_quad_o
);
  logic go_seen;

  initial
  begin
    go_seen     = 1'h0;
    cmd_valid_o = 1'h0;
    cmd_code_o  = 4'h0;
    cmd_addr_o  = 24'h0;
    cmd_data_o  = 16'h0;
    cmd_quad_o  = 1'h0;
  end

  // Fields are held until the next command, so the crossing never sees them move
  always @(negedge link_clk_i)
  begin
    cmd_valid_o <= 1'h0;
    if (go_i != go_seen)
    begin
      go_seen     <= go_i;
      cmd_valid_o <= 1'h1;
      cmd_code_o  <= code_i;
      cmd_addr_o  <= addr_i;
      cmd_data_o  <= data_i;
      cmd_quad_o  <= quad_i;
    end
  end
endmodule : fwps_host_model
